// ---- dv/puems_msg_sink.sv ----
// Message transmitter model that can stall and logs what it accepts
`timescale 1ns/1ps
module puems_msg_sink
    import puems_pkg::*;
(
    input  wire logic       clk_i,   // Clock
    input  wire logic       rst_i,   // Clear accepted count
    input  wire logic       stall_i, // Hold off acceptance
    input  wire puems_msg_t msg_i,   // Message request
    output logic            ready_o, // Accept this cycle
    output logic [2:0]      count_o  // Messages accepted
);
    puems_msg_t log_q [0:3];
    assign ready_o = !stall_i;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= 3'h0;
        end else if (msg_i.valid && ready_o) begin
            log_q[count_o[1:0]] <= msg_i;
            count_o <= count_o + 3'h1;
        end
    end
endmodule

// ---- dv/puems_top_properties.sv ----
// Port-level checks for the error mask and severity block
`timescale 1ns/1ps
module puems_top_properties
    import puems_pkg::*;
(
    input  wire logic           clk_i,               // Clock
    input  wire logic           rst_i,               // Power-on reset
    input  wire logic           link_reset_in_n_i,   // Link reset, low
    input  wire logic           global_reset_in_n_i, // Global reset, low
    input  wire puems_cfg_req_t cfg_i,               // Config request
    input  wire logic [31:0]    cfg_rdata_o,         // Read data
    input  wire logic           cfg_ack_o,           // Access done
    input  wire logic [31:0]    err_det_i,           // Error pulses
    input  wire logic           msg_ready_i,         // Message taken
    input  wire puems_msg_t     msg_o,               // Message request
    input  wire logic           hdr_log_load_o,      // Header load
    input  wire logic [4:0]     first_err_ptr_o      // First error
);
    logic any_rst_n;
    assign any_rst_n = link_reset_in_n_i & global_reset_in_n_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ========================================================================
    // Properties
    // ========================================================================
    property p_ack;
        cfg_i.req && any_rst_n |=> cfg_ack_o;
    endproperty
    property p_idle;
        !cfg_i.req |=> !cfg_ack_o && cfg_rdata_o == ZERO_WORD;
    endproperty
    property p_mask_rd;
        cfg_i.req && !cfg_i.we && cfg_i.addr == UE_MASK_OFF |=> (cfg_rdata_o & ~UE_MASK_RW) == ZERO_WORD;
    endproperty
    property p_sev_rd;
        cfg_i.req && !cfg_i.we && cfg_i.addr == UE_SEVERITY_OFF && any_rst_n
            |=> cfg_rdata_o[31:21] == 11'h000 && cfg_rdata_o[5] && cfg_rdata_o[0];
    endproperty
    property p_hold;
        msg_o.valid && !msg_ready_i && any_rst_n |=> msg_o == $past(msg_o);
    endproperty
    property p_unsup;
        (err_det_i & UE_SUPPORTED) == ZERO_WORD |=> !hdr_log_load_o;
    endproperty
    property p_ptr;
        $changed(first_err_ptr_o) && $past(any_rst_n) && !$past(rst_i) |-> hdr_log_load_o;
    endproperty
    property p_lrst;
        !any_rst_n |=> !msg_o.valid && !hdr_log_load_o && first_err_ptr_o == 5'h00;
    endproperty
    a_ack:     assert property (p_ack)     else $error("no ack after request");
    a_idle:    assert property (p_idle)    else $error("stray ack or data");
    a_mask_rd: assert property (p_mask_rd) else $error("mask fixed bits wrong");
    a_sev_rd:  assert property (p_sev_rd)  else $error("severity fixed bits wrong");
    a_hold:    assert property (p_hold)    else $error("message changed while stalled");
    a_unsup:   assert property (p_unsup)   else $error("header load without error");
    a_ptr:     assert property (p_ptr)     else $error("pointer moved without error");
    a_lrst:    assert property (p_lrst)    else $error("reporting not cleared by reset");
    c_read:    cover property (cfg_i.req ##1 cfg_ack_o);
    c_msg:     cover property (msg_o.valid && msg_ready_i);
    c_hdr:     cover property (hdr_log_load_o);
endmodule
bind puems_top puems_top_properties puems_top_properties_inst (
    .clk_i(clk_i), .rst_i(rst_i), .link_reset_in_n_i(link_reset_in_n_i),
    .global_reset_in_n_i(global_reset_in_n_i), .cfg_i(cfg_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_ack_o(cfg_ack_o), .err_det_i(err_det_i), .msg_ready_i(msg_ready_i), .msg_o(msg_o),
    .hdr_log_load_o(hdr_log_load_o), .first_err_ptr_o(first_err_ptr_o));

// ---- dv/test_puems_top.sv ----
// Directed testbench for the error mask and severity block
`timescale 1ns/1ps
module test_puems_top;
    import puems_pkg::*;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic           lrst_n = 1'b1;
    logic           global_reset_in_n = 1'b1;
    puems_cfg_req_t cfg = '0;
    logic [31:0]    err = 32'h00000000;
    logic           stall = 1'b0;
    logic [31:0]    rdata;
    logic           ack;
    logic           rdy;
    logic           hdr;
    logic [4:0]     ptr;
    logic [2:0]     cnt;
    puems_msg_t     msg;
    int             n_errors = 0;
    int             checks = 0;
    logic [3:0]     be_sel = 4'hF;
    puems_top puems_top_inst (.clk_i(clk), .rst_i(rst), .link_reset_in_n_i(lrst_n),
        .global_reset_in_n_i(global_reset_in_n), .cfg_i(cfg), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
        .err_det_i(err), .msg_ready_i(rdy), .msg_o(msg), .hdr_log_load_o(hdr), .first_err_ptr_o(ptr));
    puems_msg_sink puems_msg_sink_inst (.clk_i(clk), .rst_i(rst), .stall_i(stall), .msg_i(msg),
        .ready_o(rdy), .count_o(cnt));
    initial begin
        forever #20 clk = ~clk;
    end
    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        cfg <= '{req: 1'b1, we: we, addr: a, be: be_sel, wdata: wd};
        @(posedge clk);
        cfg <= '0;
        #1;
        check("ack", {31'h0, ack}, 32'h00000001);
        rd = rdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        acc(1'b1, a, wd, d);
    endtask
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        acc(1'b0, a, 32'h00000000, d);
        check(nm, d, exp);
    endtask
    task automatic pulse_err(input logic [31:0] bits, input logic exp_hdr);
        @(posedge clk);
        err <= bits;
        @(posedge clk);
        err <= 32'h00000000;
        #1;
        check("hdr_load", {31'h0, hdr}, {31'h0, exp_hdr});
    endtask
    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_access;
        rd_chk("mask_reset", 12'h108, 32'h00000000);
        rd_chk("sev_reset", 12'h10C, 32'h00062031);
        be_sel = 4'h4;
        wr(12'h108, 32'hFFFFFFFF);
        be_sel = 4'hF;
        rd_chk("mask_byte2", 12'h108, 32'h001F0000);
        wr(12'h108, 32'hFFFFFFFF);
        rd_chk("mask_ones", 12'h108, 32'h001FF010);
        wr(12'h10C, 32'hFFFFFFFF);
        rd_chk("sev_ones", 12'h10C, 32'h001FF031);
        wr(12'h10C, 32'h00000000);
        rd_chk("sev_zero", 12'h10C, 32'h00000021);
        rd_chk("unmapped", 12'h200, 32'h00000000);
        $display("access test done");
    endtask
    task automatic t_masked;
        wr(12'h108, 32'h00040000);
        pulse_err(32'h00040000, 1'b0);
        rd_chk("status_masked", 12'h104, 32'h00000000);
        check("ptr_masked", {27'h0, ptr}, 32'h00000000);
        check("no_msg", {29'h0, cnt}, 32'h00000000);
        wr(12'h108, 32'h00000000);
        $display("masked test done");
    endtask
    task automatic t_msgs;
        int i;
        wr(12'h10C, 32'h00040021);
        stall <= 1'b1;
        pulse_err(32'h00050000, 1'b1);
        check("ptr", {27'h0, ptr}, 32'h00000010);
        wr(12'h10C, 32'h00010021);
        rd_chk("status_set", 12'h104, 32'h00050000);
        check("stalled", {29'h0, cnt}, 32'h00000000);
        stall <= 1'b0;
        for (i = 0; i < 20 && cnt !== 3'h2; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        check("msg_count", {29'h0, cnt}, 32'h00000002);
        check("msg0", 32'(puems_msg_sink_inst.log_q[0]), 32'h00000050);
        check("msg1", 32'(puems_msg_sink_inst.log_q[1]), 32'h00000072);
        wr(12'h104, 32'h00000000);
        rd_chk("status_keep", 12'h104, 32'h00050000);
        wr(12'h104, 32'h00010000);
        rd_chk("status_clr", 12'h104, 32'h00040000);
        $display("message test done");
    endtask
    task automatic t_resets;
        wr(12'h108, 32'h001FF010);
        @(posedge clk);
        lrst_n <= 1'b0;
        @(posedge clk);
        lrst_n <= 1'b1;
        rd_chk("mask_lrst", 12'h108, 32'h00000000);
        rd_chk("status_lrst", 12'h104, 32'h00000000);
        wr(12'h10C, 32'h00000000);
        @(posedge clk);
        global_reset_in_n <= 1'b0;
        @(posedge clk);
        global_reset_in_n <= 1'b1;
        rd_chk("sev_global_reset_in", 12'h10C, 32'h00062031);
        wr(12'h108, 32'h00001000);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd_chk("mask_por", 12'h108, 32'h00000000);
        $display("reset test done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_access();
        t_masked();
        t_msgs();
        t_resets();
        final_report();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule

// ---- rtl/puems_cfg_reg.sv ----
// One configuration register with per-bit writable, fixed-one and reset patterns
`timescale 1ns/1ps
module puems_cfg_reg
    import puems_pkg::*;
#(
    parameter logic [31:0] RW_BITS   = 32'h00000000,
    parameter logic [31:0] RESET_VAL = 32'h00000000,
    parameter logic [31:0] ONE_BITS  = 32'h00000000
) (
    input  wire logic        clk_i,    // Clock
    input  wire logic        clr_i,    // Combined synchronous reset
    input  wire logic        we_i,     // Write strobe
    input  wire logic [3:0]  be_i,     // Byte enables
    input  wire logic [31:0] wdata_i,  // Write data
    output logic      [31:0] value_o   // Register view
);

    logic [31:0] store_r;
    logic [31:0] wmask;

    assign wmask = puems_be_mask(be_i) & RW_BITS;

    // ========================================================================
    // Storage: only writable bits hold state, the rest are constants
    // ========================================================================
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_bit
            if (RW_BITS[g]) begin : g_rw
                always_ff @(posedge clk_i) begin
                    if (clr_i) begin
                        store_r[g] <= RESET_VAL[g];
                    end else if (we_i && wmask[g]) begin
                        store_r[g] <= wdata_i[g];
                    end
                end
            end else begin : g_ro
                assign store_r[g] = ONE_BITS[g];
            end
        end
    endgenerate

    assign value_o = store_r;

endmodule

// ---- rtl/puems_msg_queue.sv ----
// Pending error messages, one per unmasked error, issued lowest bit first
`timescale 1ns/1ps
module puems_msg_queue
    import puems_pkg::*;
(
    input  wire logic        clk_i,       // Clock
    input  wire logic        clr_i,       // Combined synchronous reset
    input  wire logic [31:0] new_err_i,   // Unmasked errors this cycle
    input  wire logic [31:0] severity_i,  // Severity register view
    input  wire logic        ready_i,     // Message accepted by transmitter
    output puems_msg_t       msg_o        // Registered message request
);

    logic [31:0] pend_r;
    logic [31:0] pend_fatal_r;
    logic [31:0] take;
    logic        load;
    logic [4:0]  sel;

    assign load = (|pend_r) && (!msg_o.valid || ready_i);
    assign sel  = puems_lowest(pend_r);
    assign take = load ? (32'h00000001 << sel) : ZERO_WORD;

    // ========================================================================
    // Pending flags: a new event wins over the clear caused by issuing
    // ========================================================================
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            pend_r <= ZERO_WORD;
        end else begin
            pend_r <= (pend_r & ~take) | new_err_i; // RULE_18
        end
    end

    // Severity is frozen when the error is seen
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            pend_fatal_r <= ZERO_WORD;
        end else begin
            pend_fatal_r <= (pend_fatal_r & ~new_err_i) | (new_err_i & severity_i); // RULE_09
        end
    end

    // ========================================================================
    // Output register
    // ========================================================================
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            msg_o <= '0;
        end else if (load) begin
            msg_o.valid   <= 1'b1;
            msg_o.fatal   <= pend_fatal_r[sel]; // RULE_09
            msg_o.err_idx <= sel;
        end else if (ready_i) begin
            msg_o.valid <= 1'b0;
        end
    end

endmodule

// ---- rtl/puems_pkg.sv ----
// Constants, types and decode helpers for the uncorrectable error mask and severity block
package puems_pkg;

    // ========================================================================
    // Register map (byte offsets in extended configuration space)
    // ========================================================================
    localparam int          CFG_AW          = 12;
    localparam logic [11:0] UE_STATUS_OFF   = 12'h104;
    localparam logic [11:0] UE_MASK_OFF     = 12'h108;
    localparam logic [11:0] UE_SEVERITY_OFF = 12'h10C;

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int ACCESS_CONTROL_VIOLATION_BIT = 21;
    localparam int UNSUPPORTED_REQUEST_BIT      = 20;
    localparam int END_TO_END_CRC_BIT           = 19;
    localparam int MALFORMED_PACKET_BIT         = 18;
    localparam int RECEIVER_OVERFLOW_BIT        = 17;
    localparam int UNEXPECTED_COMPLETION_BIT    = 16;
    localparam int COMPLETER_ABORT_BIT          = 15;
    localparam int COMPLETION_TIMEOUT_BIT       = 14;
    localparam int FLOW_CONTROL_ERROR_BIT       = 13;
    localparam int POISONED_PACKET_BIT          = 12;
    localparam int SURPRISE_DOWN_BIT            = 5;
    localparam int LINK_PROTOCOL_ERROR_BIT      = 4;
    localparam int FIXED_ONE_BIT                = 0;

    // ========================================================================
    // Access masks and reset values
    // ========================================================================
    // Supported errors: bits 20..12 and bit 4
    localparam logic [31:0] UE_SUPPORTED    = 32'h001FF010;
    localparam logic [31:0] UE_MASK_RW      = 32'h001FF010;
    localparam logic [31:0] UE_MASK_RESET   = 32'h00000000;
    localparam logic [31:0] UE_MASK_ONES    = 32'h00000000;
    localparam logic [31:0] UE_SEV_RW       = 32'h001FF010;
    localparam logic [31:0] UE_SEV_RESET    = 32'h00062031;
    // Surprise-down severity and bit 0 read as one
    localparam logic [31:0] UE_SEV_ONES     = 32'h00000021;
    localparam logic [31:0] UE_STATUS_RESET = 32'h00000000;
    localparam logic [31:0] ZERO_WORD       = 32'h00000000;

    // ========================================================================
    // Carriers
    // ========================================================================
    typedef struct packed {
        logic              req;
        logic              we;
        logic [CFG_AW-1:0] addr;
        logic [3:0]        be;
        logic [31:0]       wdata;
    } puems_cfg_req_t;

    typedef struct packed {
        logic       valid;
        logic       fatal;
        logic [4:0] err_idx;
    } puems_msg_t;

    // Index of lowest set bit; zero when none is set
    function automatic logic [4:0] puems_lowest(input logic [31:0] vec);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (vec[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    // Byte-enable expansion to a 32-bit write mask
    function automatic logic [31:0] puems_be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

endpackage

// ---- rtl/puems_top.sv ----
// Uncorrectable error status, mask and severity registers with reporting gates
// What this block does
// RULE_01: A masked error sets no status, sends no message, logs no header, keeps pointer.
// RULE_02: Mask register sits at 108h and resets to all zero.
// RULE_03: Mask bits 31:22 and 11:6 read zero and ignore writes.
// RULE_04: Mask bit 21, access-control violation, always reads zero.
// RULE_05: Mask bit 5, surprise down, is read-only zero.
// RULE_06: Mask bits 20 to 16 are read-write, reset zero.
// RULE_07: Mask bits 15 to 12 and 4 are read-write, reset zero.
// RULE_08: Mask bits 3:0 read zero.
// RULE_09: Severity one sends a fatal message, zero a nonfatal one.
// RULE_10: Severity register sits at 10Ch.
// RULE_11: Severity register resets to 0006 2031h.
// RULE_12: Severity bits 20 to 12 are read-write, aligned with the mask bits.
// RULE_13: Severity bits 31:21 are read-only zero.
// RULE_14: Link reset, global reset or power-on reset restore defaults.
// RULE_15: Severity bit 4 is read-write and selects fatal or nonfatal.
// RULE_16: Severity bits 5 and 0 always read one.
// RULE_17: Status bits clear only on a written one; zero leaves them.
// RULE_18: Each unmasked error yields one message typed by severity at detection.
`timescale 1ns/1ps
module puems_top
    import puems_pkg::*;
(
    input  wire logic           clk_i,               // 25 MHz clock
    input  wire logic           rst_i,               // Power-on reset, sync, high
    input  wire logic           link_reset_in_n_i,   // Link reset, low
    input  wire logic           global_reset_in_n_i, // Global reset, low
    input  wire puems_cfg_req_t cfg_i,               // Configuration access request
    output logic [31:0]         cfg_rdata_o,         // Read data
    output logic                cfg_ack_o,           // Access complete pulse
    input  wire logic [31:0]    err_det_i,           // Detected error pulses by bit
    input  wire logic           msg_ready_i,         // Transmitter takes message
    output puems_msg_t          msg_o,               // Error message request
    output logic                hdr_log_load_o,      // Header log load pulse
    output logic [4:0]          first_err_ptr_o      // First error pointer
);

    logic        clr;
    logic        hit_status;
    logic        hit_mask;
    logic        hit_sev;
    logic        wr;
    logic [31:0] mask_val;
    logic [31:0] sev_val;
    logic [31:0] status_r;
    logic [31:0] status_nxt;
    logic [31:0] unmasked;
    logic [31:0] w1c;
    logic [31:0] rdata_nxt;

    // ========================================================================
    // Reset and decode
    // ========================================================================
    assign clr        = rst_i | ~link_reset_in_n_i | ~global_reset_in_n_i; // RULE_14
    assign wr         = cfg_i.req & cfg_i.we;
    assign hit_status = (cfg_i.addr[CFG_AW-1:2] == UE_STATUS_OFF[CFG_AW-1:2]);
    assign hit_mask   = (cfg_i.addr[CFG_AW-1:2] == UE_MASK_OFF[CFG_AW-1:2]);   // RULE_02
    assign hit_sev    = (cfg_i.addr[CFG_AW-1:2] == UE_SEVERITY_OFF[CFG_AW-1:2]); // RULE_10

    // ========================================================================
    // Mask and severity registers
    // ========================================================================
    // Writable bits 20..12 and 4; all else reads zero
    puems_cfg_reg #(
        .RW_BITS   (UE_MASK_RW),    // RULE_06 RULE_07
        .RESET_VAL (UE_MASK_RESET),
        .ONE_BITS  (UE_MASK_ONES)   // RULE_05
    ) u_mask (
        .clk_i   (clk_i),
        .clr_i   (clr),
        .we_i    (wr && hit_mask),  // RULE_03
        .be_i    (cfg_i.be),
        .wdata_i (cfg_i.wdata),
        .value_o (mask_val)         // RULE_04
    );

    // Writable bits 20..12 and 4; bits 5 and 0 fixed at one
    puems_cfg_reg #(
        .RW_BITS   (UE_SEV_RW),
        .RESET_VAL (UE_SEV_RESET),  // RULE_11
        .ONE_BITS  (UE_SEV_ONES)
    ) u_sev (
        .clk_i   (clk_i),
        .clr_i   (clr),
        .we_i    (wr && hit_sev),   // RULE_12
        .be_i    (cfg_i.be),
        .wdata_i (cfg_i.wdata),
        .value_o (sev_val)          // RULE_16
    );

    // ========================================================================
    // Status capture with gating and write-one-to-clear
    // ========================================================================
    assign unmasked = err_det_i & UE_SUPPORTED & ~mask_val; // RULE_01
    assign w1c      = (wr && hit_status) ? (cfg_i.wdata & puems_be_mask(cfg_i.be)) : ZERO_WORD;
    // A new error wins over a clear in the same cycle
    assign status_nxt = (status_r & ~w1c) | unmasked; // RULE_17

    always_ff @(posedge clk_i) begin
        if (clr) begin
            status_r <= UE_STATUS_RESET;
        end else begin
            status_r <= status_nxt & UE_SUPPORTED;
        end
    end

    // Header log and first error pointer follow only unmasked errors
    always_ff @(posedge clk_i) begin
        if (clr) begin
            hdr_log_load_o <= 1'b0;
        end else begin
            hdr_log_load_o <= |unmasked; // RULE_01
        end
    end

    always_ff @(posedge clk_i) begin
        if (clr) begin
            first_err_ptr_o <= 5'h00;
        end else if ((|unmasked) && ((status_r & ~w1c) == ZERO_WORD)) begin
            first_err_ptr_o <= puems_lowest(unmasked); // RULE_01
        end
    end

    // ========================================================================
    // Message generation
    // ========================================================================
    puems_msg_queue u_msg (
        .clk_i      (clk_i),
        .clr_i      (clr),
        .new_err_i  (unmasked),   // RULE_18
        .severity_i (sev_val),    // RULE_15
        .ready_i    (msg_ready_i),
        .msg_o      (msg_o)
    );

    // ========================================================================
    // Read path: one cycle answer, unmapped offsets read zero
    // ========================================================================
    always_comb begin
        rdata_nxt = ZERO_WORD;
        if (hit_status) begin
            rdata_nxt = status_r;
        end else if (hit_mask) begin
            rdata_nxt = mask_val; // RULE_08
        end else if (hit_sev) begin
            rdata_nxt = sev_val;  // RULE_13
        end
    end

    always_ff @(posedge clk_i) begin
        if (clr) begin
            cfg_ack_o   <= 1'b0;
            cfg_rdata_o <= ZERO_WORD;
        end else begin
            cfg_ack_o   <= cfg_i.req;
            cfg_rdata_o <= (cfg_i.req && !cfg_i.we) ? rdata_nxt : ZERO_WORD;
        end
    end

endmodule
